// ===== core/msr_pkg.sv
`default_nettype none
package msr_pkg;
    // modbus function codes seen on the command side
    localparam logic [7:0] FUNC_WRITE_SINGLE = 8'h06;
    localparam logic [7:0] FUNC_WRITE_MULTI = 8'h10;
    // rotation frame kinds, all broadcast
    localparam logic [7:0] FUNC_ROT_DATA = 8'h06;
    localparam logic [7:0] FUNC_ROT_DATA_LAST = 8'h65;
    localparam logic [7:0] FUNC_ROT_SWITCH = 8'h64;
    localparam logic [7:0] BROADCAST_ADDR = 8'h00;
    // trigger registers
    localparam logic [15:0] REG_STORE_ALL_TRIGGER = 16'h2328;
    localparam logic [15:0] REG_PERSISTENT_WRITE_MODE_TRIGGER = 16'h232a;
    localparam logic [15:0] REG_RECALC_TRIGGER = 16'h2332;
    localparam logic [15:0] TRIGGER_VALUE = 16'h0001;
    // link protocol select
    localparam logic [1:0] PROTO_MODBUS_SLAVE = 2'h0;
    localparam logic [1:0] PROTO_ROT_MEMBER = 2'h1;
    localparam logic [1:0] PROTO_ROT_CONTROL = 2'h2;
    // rotation start select
    localparam logic START_BY_INPUT = 1'h0;
    localparam logic START_CONTINUOUS = 1'h1;
    // communication error action select
    localparam logic [2:0] ERR_TRIP = 3'h0;
    localparam logic [2:0] ERR_DECEL_TRIP = 3'h1;
    localparam logic [2:0] ERR_IGNORE = 3'h2;
    localparam logic [2:0] ERR_COAST = 3'h3;
    localparam logic [2:0] ERR_DECEL_STOP = 3'h4;
    // stations
    localparam logic [7:0] CONTROL_STATION = 8'h01;
    localparam logic [7:0] MASTER_STATION_MIN = 8'h01;
    localparam logic [7:0] MASTER_STATION_MAX = 8'h08;
    localparam int MAX_SLOTS = 5;
    // timing
    localparam int CLK_HZ = 40_000_000;
    localparam int MS_PER_S = 1000;
    localparam int TIMEOUT_UNIT_MS = 10;
    localparam int SILENT_US = 4000;
    localparam logic [15:0] TIMEOUT_DISABLED = 16'h0000;
    // frame layout
    localparam int FRAME_BYTES = 9;
    localparam logic [3:0] CRC_LO_IDX = 4'h7;
    localparam logic [3:0] LAST_IDX = 4'h8;
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'ha001;

    typedef enum logic [2:0] {
        ROT_OFF = 3'b000,
        ROT_START_WAIT = 3'b001,
        ROT_SWITCH_TX = 3'b010,
        ROT_DATA_TX = 3'b011,
        ROT_RX_WAIT = 3'b100,
        ROT_GAP = 3'b101,
        ROT_STOPPED = 3'b110
    } msr_rot_state_t;
endpackage
`default_nettype wire

// ===== core/msr_store_rotation.sv
// Notes on behaviour
// - plain 06h/10h writes update only the volatile copy, never the store
// - after power-up the volatile copy is reloaded from the store
// - writing 1 to store_all_trigger with 06h stores the whole parameter memory
// - a readable coil shows while a store is in progress
// - writing 1 to persistent_write_mode_trigger with 06h enters persistent-write mode
// - in that mode the next 06h write goes to both copies, then mode ends
// - any other command in that mode cancels it without storing
// - writing 1 to recalc_trigger with 06h recomputes internal control variables
// - a master writes up to five configured values to other nodes
// - controller passes master role to the next master in sequence until a reception timeout halts it
// - station 01 is the fixed controller and may also be master or slave
// - at most eight masters, first and last station 01..08, first not above last (last is only capped at 08 and raised to the unclamped first)
// - protocol select 00 plain slave, 01 rotation member, 02 rotation controller
// - start select 00 waits for start input, 01 runs continuously
// - error action 00 trip, 01 decel-trip, 02 ignore, 03 coast, 04 decel stop
// - timeout setting 0 disables detection, otherwise hundredths of a second
// - rotation frames are broadcast; data for other stations is discarded
// - controller as master sends switch after own data, silent gap and wait time
// - timeout timer starts with reception wait; expiry applies the error action
// - continuous start makes the controller transmit right after power-on
`default_nettype none
module msr_store_rotation #(
    parameter int SLOTS = msr_pkg::MAX_SLOTS,
    parameter int CYCLES_PER_MS = msr_pkg::CLK_HZ / msr_pkg::MS_PER_S,
    parameter int SILENT_CYCLES = msr_pkg::SILENT_US * (msr_pkg::CLK_HZ / 1_000_000)
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // decoded modbus commands addressed to this node
    input wire logic cmdValid,
    input wire logic [7:0] cmdFunc,
    input wire logic [15:0] cmdAddr,
    input wire logic [15:0] cmdData,
    // parameter memory
    output logic volWrEn,
    output logic [15:0] volWrAddr,
    output logic [15:0] volWrData,
    output logic nvmWrEn,
    output logic [15:0] nvmWrAddr,
    output logic [15:0] nvmWrData,
    output logic storeAllReq,
    output logic restoreReq,
    input wire logic nvmBusy,
    output logic storeBusyCoil,
    output logic recalcReq,
    // settings, taken once after reset
    input wire logic [7:0] stationNumberSetting,
    input wire logic [1:0] linkProtocolSelect,
    input wire logic [7:0] firstMasterStation,
    input wire logic [7:0] lastMasterStation,
    input wire logic rotationStartSelect,
    input wire logic [2:0] errorActionSelect,
    input wire logic [15:0] timeoutSetting,
    input wire logic [9:0] waitTimeSetting,
    // master transmit slots
    input wire logic [2:0] slotCount,
    input wire logic [SLOTS-1:0][7:0] slotDest,
    input wire logic [SLOTS-1:0][15:0] slotReg,
    input wire logic [SLOTS-1:0][15:0] slotValue,
    // start terminal
    input wire logic rotationStartInput,
    // received rotation frames, already checked
    input wire logic rxFrameValid,
    input wire logic [7:0] rxFunc,
    input wire logic [7:0] rxDest,
    input wire logic [15:0] rxReg,
    input wire logic [15:0] rxData,
    // transmit byte stream
    output logic txByteValid,
    output logic [7:0] txByte,
    output logic txFrameEnd,
    input wire logic txByteReady,
    // error reporting
    output logic commErrorPulse,
    output logic [2:0] errorAction,
    output logic rotationStopped
);
    import msr_pkg::*;

    localparam int CYCLES_PER_TIMEOUT_UNIT = TIMEOUT_UNIT_MS * CYCLES_PER_MS;

    if (SLOTS < 1 || SLOTS > 7 || CYCLES_PER_MS < 1 || SILENT_CYCLES < 1) begin : gCheck
        $error("msr_store_rotation: unsupported parameter values");
    end

    function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] x;
        x = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
        end
        return x;
    endfunction

    // settings captured once; changes need a reset to take effect
    logic cfgLoaded;
    logic [7:0] ownStation;
    logic [1:0] proto;
    logic [7:0] firstM;
    logic [7:0] lastM;
    logic startSel;
    logic [15:0] timeoutCfg;
    logic [9:0] waitCfg;
    logic [2:0] slotsUsed;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cfgLoaded <= 1'b0;
            ownStation <= 8'h00;
            proto <= PROTO_MODBUS_SLAVE;
            firstM <= MASTER_STATION_MIN;
            lastM <= MASTER_STATION_MIN;
            startSel <= START_BY_INPUT;
            timeoutCfg <= TIMEOUT_DISABLED;
            waitCfg <= 10'h000;
            errorAction <= ERR_TRIP;
            slotsUsed <= 3'h1;
        end else if (!cfgLoaded) begin
            cfgLoaded <= 1'b1;
            ownStation <= stationNumberSetting;
            proto <= linkProtocolSelect;
            startSel <= rotationStartSelect;
            timeoutCfg <= timeoutSetting;
            waitCfg <= waitTimeSetting;
            errorAction <= errorActionSelect;
            // first is clamped to 01..08; last is capped at 08 and raised to the unclamped first setting if below it
            firstM <= (firstMasterStation < MASTER_STATION_MIN) ? MASTER_STATION_MIN :
                      (firstMasterStation > MASTER_STATION_MAX) ? MASTER_STATION_MAX : firstMasterStation;
            lastM <= (lastMasterStation > MASTER_STATION_MAX) ? MASTER_STATION_MAX :
                     (lastMasterStation < firstMasterStation) ? firstMasterStation : lastMasterStation;
            slotsUsed <= (slotCount == 3'h0) ? 3'h1 :
                         (slotCount > 3'(SLOTS)) ? 3'(SLOTS) : slotCount;
        end
    end

    // ---------------- parameter store handling ----------------
    logic persistMode;
    logic isSingle;
    logic isTrigger;
    logic rxForMe;
    assign isSingle = cmdFunc == FUNC_WRITE_SINGLE;
    assign isTrigger = isSingle && cmdData == TRIGGER_VALUE &&
                       (cmdAddr == REG_STORE_ALL_TRIGGER || cmdAddr == REG_PERSISTENT_WRITE_MODE_TRIGGER ||
                        cmdAddr == REG_RECALC_TRIGGER);
    assign rxForMe = rxFrameValid && rxDest == ownStation &&
                     (rxFunc == FUNC_ROT_DATA || rxFunc == FUNC_ROT_DATA_LAST);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            persistMode <= 1'b0;
        end else if (cmdValid) begin
            if (isSingle && cmdAddr == REG_PERSISTENT_WRITE_MODE_TRIGGER && cmdData == TRIGGER_VALUE) begin
                persistMode <= 1'b1;
            end else begin
                // the write that uses the mode, or any other command, ends it
                persistMode <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            volWrEn <= 1'b0;
            volWrAddr <= 16'h0000;
            volWrData <= 16'h0000;
            nvmWrEn <= 1'b0;
            nvmWrAddr <= 16'h0000;
            nvmWrData <= 16'h0000;
        end else begin
            volWrEn <= 1'b0;
            nvmWrEn <= 1'b0;
            if (cmdValid && !isTrigger && (isSingle || cmdFunc == FUNC_WRITE_MULTI)) begin
                volWrEn <= 1'b1;
                volWrAddr <= cmdAddr;
                volWrData <= cmdData;
                if (isSingle && persistMode) begin
                    nvmWrEn <= 1'b1;
                    nvmWrAddr <= cmdAddr;
                    nvmWrData <= cmdData;
                end
            end else if (!cmdValid && rxForMe) begin
                // peer data lands only in the volatile copy, like a plain host write
                volWrEn <= 1'b1;
                volWrAddr <= rxReg;
                volWrData <= rxData;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            storeAllReq <= 1'b0;
            recalcReq <= 1'b0;
            restoreReq <= 1'b0;
            storeBusyCoil <= 1'b0;
        end else begin
            storeAllReq <= cmdValid && isSingle && cmdAddr == REG_STORE_ALL_TRIGGER &&
                           cmdData == TRIGGER_VALUE;
            recalcReq <= cmdValid && isSingle && cmdAddr == REG_RECALC_TRIGGER &&
                         cmdData == TRIGGER_VALUE;
            // uncommitted volatile contents are dropped by reloading the stored image
            restoreReq <= !cfgLoaded;
            // covers the cycle between the request and the store raising its busy
            storeBusyCoil <= nvmBusy || storeAllReq || nvmWrEn;
        end
    end

    // ---------------- frame transmitter ----------------
    logic txStart;
    logic [7:0] txFunc;
    logic [7:0] txDest;
    logic [15:0] txReg;
    logic [15:0] txData;
    logic [7:0] frameBuf [FRAME_BYTES];
    logic [3:0] txIdx;
    logic [15:0] crc;
    logic [15:0] next_crc;
    logic txAccept;
    logic txDone;

    assign txAccept = txByteValid && txByteReady;
    assign next_crc = crcByte(crc, txByte);
    assign txFrameEnd = txByteValid && txIdx == LAST_IDX;
    assign txDone = txAccept && txIdx == LAST_IDX;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            txByteValid <= 1'b0;
            txByte <= 8'h00;
            txIdx <= 4'h0;
            crc <= CRC_INIT;
            for (int i = 0; i < FRAME_BYTES; i++) begin
                frameBuf[i] <= 8'h00;
            end
        end else if (txStart) begin
            frameBuf[0] <= BROADCAST_ADDR;
            frameBuf[1] <= txFunc;
            frameBuf[2] <= txDest;
            frameBuf[3] <= txReg[15:8];
            frameBuf[4] <= txReg[7:0];
            frameBuf[5] <= txData[15:8];
            frameBuf[6] <= txData[7:0];
            txByte <= BROADCAST_ADDR;
            txByteValid <= 1'b1;
            txIdx <= 4'h0;
            crc <= CRC_INIT;
        end else if (txAccept) begin
            if (txIdx == LAST_IDX) begin
                txByteValid <= 1'b0;
            end else begin
                txIdx <= txIdx + 4'h1;
                if (txIdx < CRC_LO_IDX) begin
                    crc <= next_crc;
                end
                if (txIdx + 4'h1 < CRC_LO_IDX) begin
                    txByte <= frameBuf[txIdx + 4'h1];
                end else if (txIdx + 4'h1 == CRC_LO_IDX) begin
                    txByte <= next_crc[7:0];
                end else begin
                    txByte <= crc[15:8];
                end
            end
        end
    end

    // ---------------- peer rotation ----------------
    msr_rot_state_t rotState;
    logic [7:0] curMaster;
    logic [7:0] nextMaster;
    logic [2:0] slotIdx;
    logic [31:0] timer;
    logic [31:0] gapCycles;
    logic [31:0] timeoutCycles;
    logic isController;
    logic switchForMe;
    logic timedOut;
    logic lastSlot;

    assign isController = proto == PROTO_ROT_CONTROL && ownStation == CONTROL_STATION;
    assign nextMaster = (curMaster >= lastM) ? firstM : curMaster + 8'h01;
    assign switchForMe = rxFrameValid && rxFunc == FUNC_ROT_SWITCH && rxDest == ownStation;
    assign gapCycles = 32'(SILENT_CYCLES) + 32'(waitCfg) * 32'(CYCLES_PER_MS);
    assign timeoutCycles = 32'(timeoutCfg) * 32'(CYCLES_PER_TIMEOUT_UNIT);
    assign timedOut = timeoutCfg != TIMEOUT_DISABLED && timer >= timeoutCycles;
    assign lastSlot = slotIdx + 3'h1 >= slotsUsed;
    assign rotationStopped = rotState == ROT_STOPPED;

    always_comb begin
        txStart = 1'b0;
        txFunc = FUNC_ROT_DATA;
        txDest = 8'h00;
        txReg = 16'h0000;
        txData = 16'h0000;
        if (!txByteValid) begin
            case (rotState)
                ROT_SWITCH_TX: begin
                    txStart = 1'b1;
                    txFunc = FUNC_ROT_SWITCH;
                    txDest = curMaster;
                end
                ROT_DATA_TX: begin
                    txStart = 1'b1;
                    txFunc = lastSlot ? FUNC_ROT_DATA_LAST : FUNC_ROT_DATA;
                    txDest = slotDest[slotIdx];
                    txReg = slotReg[slotIdx];
                    txData = slotValue[slotIdx];
                end
                default: begin
                    txStart = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rotState <= ROT_OFF;
            curMaster <= MASTER_STATION_MIN;
            slotIdx <= 3'h0;
            timer <= 32'h0000_0000;
            commErrorPulse <= 1'b0;
        end else begin
            commErrorPulse <= 1'b0;
            case (rotState)
                ROT_OFF: begin
                    if (cfgLoaded) begin
                        curMaster <= firstM;
                        timer <= 32'h0000_0000;
                        if (isController) begin
                            rotState <= ROT_START_WAIT;
                        end else if (proto == PROTO_ROT_MEMBER) begin
                            rotState <= ROT_RX_WAIT;
                        end
                    end
                end
                ROT_START_WAIT: begin
                    if (startSel == START_CONTINUOUS || rotationStartInput) begin
                        slotIdx <= 3'h0;
                        rotState <= (curMaster == ownStation) ? ROT_DATA_TX : ROT_SWITCH_TX;
                    end
                end
                ROT_SWITCH_TX: begin
                    if (txDone) begin
                        timer <= 32'h0000_0000;
                        rotState <= ROT_RX_WAIT;
                    end
                end
                ROT_DATA_TX: begin
                    if (txDone) begin
                        timer <= 32'h0000_0000;
                        if (!lastSlot) begin
                            slotIdx <= slotIdx + 3'h1;
                        end else if (isController) begin
                            rotState <= ROT_GAP;
                        end else begin
                            rotState <= ROT_RX_WAIT;
                        end
                    end
                end
                ROT_RX_WAIT: begin
                    timer <= timer + 32'h0000_0001;
                    if (!isController && switchForMe) begin
                        slotIdx <= 3'h0;
                        rotState <= ROT_DATA_TX;
                    end else if (!isController && rxFrameValid) begin
                        timer <= 32'h0000_0000;
                    end else if (isController && rxFrameValid && rxFunc == FUNC_ROT_DATA_LAST) begin
                        timer <= 32'h0000_0000;
                        rotState <= ROT_GAP;
                    end else if (timedOut) begin
                        commErrorPulse <= 1'b1;
                        timer <= 32'h0000_0000;
                        // a timed-out controller halts until the next reset
                        if (isController) begin
                            rotState <= ROT_STOPPED;
                        end
                    end
                end
                ROT_GAP: begin
                    timer <= timer + 32'h0000_0001;
                    if (timer + 32'h0000_0001 >= gapCycles) begin
                        timer <= 32'h0000_0000;
                        curMaster <= nextMaster;
                        slotIdx <= 3'h0;
                        rotState <= (nextMaster == ownStation) ? ROT_DATA_TX : ROT_SWITCH_TX;
                    end
                end
                ROT_STOPPED: begin
                    rotState <= ROT_STOPPED;
                end
                default: begin
                    rotState <= ROT_OFF;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ===== tb/msr_peer_model.sv
`default_nettype none
module msr_peer_model (
    // transmit side of the node
    input wire logic clk,
    input wire logic reset,
    input wire logic mute,
    input wire logic txByteValid,
    input wire logic [7:0] txByte,
    output logic txByteReady,
    // frames from the addressed master
    output logic rxFrameValid,
    output logic [7:0] rxFunc,
    output logic [7:0] rxDest,
    output logic [15:0] rxReg,
    output logic [15:0] rxData
);
    timeunit 1ns;
    timeprecision 1ps;
    import msr_pkg::*;
    logic [7:0] fr [0:8];
    int n = 0;
    initial begin
        txByteReady = 1'h0;
        rxFrameValid = 1'h0;
        {rxFunc, rxDest, rxReg, rxData} = 48'h0;
        forever begin
            @(posedge clk);
            if (txByteValid && txByteReady) begin
                fr[n] = txByte;
                n++;
            end
            #1;
            // stall every other cycle so the sender must hold its byte
            txByteReady = !txByteReady && !reset;
            if (n == 9) begin
                n = 0;
                // the next consecutive station answers with its last data frame
                if (fr[1] == FUNC_ROT_SWITCH && !mute) begin
                    repeat (10) @(posedge clk);
                    #1;
                    rxFrameValid = 1'h1;
                    {rxFunc, rxDest, rxReg, rxData} = {FUNC_ROT_DATA_LAST, 8'h07, 16'h0040, 16'h0099};
                    @(posedge clk);
                    #1;
                    rxFrameValid = 1'h0;
                    {rxFunc, rxDest, rxReg, rxData} = ~{rxFunc, rxDest, rxReg, rxData};
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== tb/msr_store_rotation_asserts.sv
`default_nettype none
module msr_store_rotation_asserts (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // command and memory side
    input wire logic cmdValid,
    input wire logic [7:0] cmdFunc,
    input wire logic [15:0] cmdAddr,
    input wire logic [15:0] cmdData,
    input wire logic volWrEn,
    input wire logic [15:0] volWrAddr,
    input wire logic [15:0] volWrData,
    input wire logic nvmWrEn,
    input wire logic [15:0] nvmWrAddr,
    input wire logic storeAllReq,
    input wire logic restoreReq,
    input wire logic nvmBusy,
    input wire logic storeBusyCoil,
    input wire logic recalcReq,
    // transmit stream
    input wire logic txByteValid,
    input wire logic [7:0] txByte,
    input wire logic txFrameEnd,
    input wire logic txByteReady
);
    timeunit 1ns;
    timeprecision 1ps;
    import msr_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    logic wr;
    logic trig;
    logic one;
    assign wr = cmdValid && cmdFunc == FUNC_WRITE_SINGLE;
    assign one = cmdData == TRIGGER_VALUE;
    assign trig = cmdAddr inside {REG_STORE_ALL_TRIGGER, REG_PERSISTENT_WRITE_MODE_TRIGGER, REG_RECALC_TRIGGER};
    sequence s_mode;
        wr && cmdAddr == REG_PERSISTENT_WRITE_MODE_TRIGGER && one;
    endsequence
    property p_store;
        wr && cmdAddr == REG_STORE_ALL_TRIGGER && one |=> storeAllReq && !volWrEn;
    endproperty
    a_store: assert property (p_store) else $error("store-all not raised");
    property p_recalc;
        wr && cmdAddr == REG_RECALC_TRIGGER && one |=> recalcReq && !volWrEn;
    endproperty
    a_recalc: assert property (p_recalc) else $error("recalc not raised");
    property p_vol;
        wr && !trig |=> volWrEn && volWrAddr == $past(cmdAddr) && volWrData == $past(cmdData);
    endproperty
    a_vol: assert property (p_vol) else $error("volatile write wrong");
    property p_multi;
        cmdValid && cmdFunc == FUNC_WRITE_MULTI |=> volWrEn && !nvmWrEn && !storeAllReq;
    endproperty
    a_multi: assert property (p_multi) else $error("multi write reached store");
    property p_persist;
        s_mode ##2 (wr && !trig) |=> nvmWrEn && volWrEn && nvmWrAddr == $past(cmdAddr);
    endproperty
    a_persist: assert property (p_persist) else $error("persistent write missing");
    property p_once;
        s_mode ##2 (wr && !trig) ##2 (wr && !trig) |=> !nvmWrEn;
    endproperty
    a_once: assert property (p_once) else $error("persistent mode not left");
    property p_cancel;
        s_mode ##2 (cmdValid && cmdFunc != FUNC_WRITE_SINGLE) ##2 (wr && !trig) |=> !nvmWrEn;
    endproperty
    a_cancel: assert property (p_cancel) else $error("persistent mode not cancelled");
    property p_coil;
        storeAllReq || nvmBusy |=> storeBusyCoil;
    endproperty
    a_coil: assert property (p_coil) else $error("store coil low while storing");
    property p_hold;
        txByteValid && !txByteReady |=> txByteValid && $stable(txByte);
    endproperty
    a_hold: assert property (p_hold) else $error("tx byte dropped before accept");
    property p_end;
        txFrameEnd |-> txByteValid;
    endproperty
    a_end: assert property (p_end) else $error("frame end without byte");
    property p_restore;
        restoreReq |=> !restoreReq;
    endproperty
    a_restore: assert property (p_restore) else $error("restore longer than one cycle");
endmodule
`default_nettype wire

// ===== tb/tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import msr_pkg::*;
    logic clk = 1'h0;
    logic reset = 1'h1;
    logic cmdValid = 1'h0;
    logic [7:0] cmdFunc = 8'h00;
    logic [15:0] cmdAddr = 16'h0000;
    logic [15:0] cmdData = 16'h0000;
    logic volWrEn, nvmWrEn, storeAllReq, restoreReq, storeBusyCoil, recalcReq;
    logic [15:0] volWrAddr, volWrData, nvmWrAddr, nvmWrData, rxReg, rxData;
    logic nvmBusy = 1'h0;
    logic [7:0] stationNumberSetting = CONTROL_STATION;
    logic [1:0] linkProtocolSelect = PROTO_ROT_CONTROL;
    logic [7:0] firstMasterStation = 8'h01;
    logic [7:0] lastMasterStation = 8'h02;
    logic rotationStartSelect = START_CONTINUOUS;
    logic [2:0] errorActionSelect = ERR_COAST;
    logic [15:0] timeoutSetting = 16'h0001;
    logic [9:0] waitTimeSetting = 10'h002;
    logic [2:0] slotCount = 3'h1;
    logic [4:0][7:0] slotDest = {5{8'h03}};
    logic [4:0][15:0] slotReg = {5{16'h1234}};
    logic [4:0][15:0] slotValue = {5{16'habcd}};
    logic rotationStartInput = 1'h0;
    logic rxFrameValid, txByteValid, txFrameEnd, txByteReady, commErrorPulse, rotationStopped;
    logic [7:0] rxFunc, rxDest, txByte;
    logic [2:0] errorAction;
    logic mute = 1'h0;
    int mismatches = 0;
    int checked = 0;
    logic [7:0] f [0:8];
    int gap;
    // short counts keep the rotation to tens of cycles
    msr_store_rotation #(.CYCLES_PER_MS(4), .SILENT_CYCLES(8)) dut_u (.*);
    msr_peer_model peer_u (.*);
    always #12.5 clk = ~clk;
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        checked++;
        if (s !== e) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic give_verdict();
        if (mismatches == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic cmd(input logic [7:0] fn, input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        #1;
        {cmdValid, cmdFunc, cmdAddr, cmdData} = {1'h1, fn, a, d};
        @(posedge clk);
        #1;
        cmdValid = 1'h0;
    endtask
    task automatic t_frame(input logic [7:0] fn, input logic [7:0] dst, input logic [31:0] rd);
        int n;
        n = 0;
        gap = 0;
        while (n < 9 && gap < 2000) begin
            @(posedge clk);
            gap++;
            if (txByteValid === 1'h1 && txByteReady === 1'h1) begin
                f[n] = txByte;
                n++;
            end
        end
        chk(n, 9);
        chk(f[0], BROADCAST_ADDR);
        chk(f[1], fn);
        chk(f[2], dst);
        chk({f[3], f[4], f[5], f[6]}, rd);
    endtask
    task automatic t_rotation();
        t_frame(FUNC_ROT_DATA_LAST, 8'h03, 32'h1234abcd);
        t_frame(FUNC_ROT_SWITCH, 8'h02, 32'h0);
        chk(gap > 8 + 2 * 4 + 9, 1);
        t_frame(FUNC_ROT_DATA_LAST, 8'h03, 32'h1234abcd);
    endtask
    task automatic t_mem();
        cmd(FUNC_WRITE_SINGLE, 16'h0010, 16'h5a5a);
        chk({volWrEn, nvmWrEn, volWrData}, {2'h2, 16'h5a5a});
        cmd(FUNC_WRITE_MULTI, REG_STORE_ALL_TRIGGER, TRIGGER_VALUE);
        chk({storeAllReq, volWrEn}, 2'h1);
        cmd(FUNC_WRITE_SINGLE, REG_STORE_ALL_TRIGGER, TRIGGER_VALUE);
        chk({storeAllReq, volWrEn}, 2'h2);
        nvmBusy = 1'h1;
        repeat (3) @(posedge clk);
        #1;
        chk(storeBusyCoil, 1'h1);
        nvmBusy = 1'h0;
        repeat (2) @(posedge clk);
        #1;
        chk(storeBusyCoil, 1'h0);
    endtask
    task automatic t_persist();
        cmd(FUNC_WRITE_SINGLE, REG_PERSISTENT_WRITE_MODE_TRIGGER, TRIGGER_VALUE);
        chk({volWrEn, nvmWrEn}, 2'h0);
        cmd(FUNC_WRITE_SINGLE, 16'h0020, 16'h1111);
        chk({volWrEn, nvmWrEn, nvmWrAddr}, {2'h3, 16'h0020});
        cmd(FUNC_WRITE_SINGLE, 16'h0021, 16'h2222);
        chk({volWrEn, nvmWrEn}, 2'h2);
        cmd(FUNC_WRITE_SINGLE, REG_PERSISTENT_WRITE_MODE_TRIGGER, TRIGGER_VALUE);
        cmd(8'h03, 16'h0000, 16'h0000);
        cmd(FUNC_WRITE_SINGLE, 16'h0022, 16'h3333);
        chk({volWrEn, nvmWrEn}, 2'h2);
        cmd(FUNC_WRITE_SINGLE, REG_RECALC_TRIGGER, TRIGGER_VALUE);
        chk({recalcReq, volWrEn}, 2'h2);
        cmd(FUNC_WRITE_SINGLE, REG_RECALC_TRIGGER, 16'h0002);
        chk({recalcReq, volWrEn}, 2'h1);
    endtask
    task automatic t_timeout();
        int i;
        chk(rotationStopped, 1'h0);
        mute = 1'h1;
        for (i = 0; i < 1000 && commErrorPulse !== 1'h1; i++) begin
            @(posedge clk);
        end
        #1;
        chk({i < 1000, rotationStopped}, 2'h3);
        chk(errorAction, ERR_COAST);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        #1;
        reset = 1'h0;
        @(posedge clk);
        #1;
        chk(restoreReq, 1'h1);
        t_rotation();
        t_mem();
        t_persist();
        t_timeout();
        give_verdict();
    end
    initial begin
        // far beyond the few hundred cycles the sequence needs
        #300000;
        mismatches++;
        give_verdict();
    end
endmodule
bind msr_store_rotation msr_store_rotation_asserts chk_u (.*);
`default_nettype wire
